//--- design/rscc_pkg.sv
package rscc_pkg;

  // Bit positions in the reset cause and control register.
  localparam int BIT_POR    = 0;
  localparam int BIT_BOR    = 1;
  localparam int BIT_IDLE   = 2;
  localparam int BIT_SLEEP  = 3;
  localparam int BIT_WATCHDOG_TIMEOUT_FLAG   = 4;
  localparam int BIT_WDTEN  = 5;
  localparam int BIT_SWR    = 6;
  localparam int BIT_EXTERNAL_PIN_RESET_FLAG   = 7;
  localparam int BIT_VREG   = 8;
  localparam int BIT_IOP    = 14;
  localparam int BIT_TRAP   = 15;

  localparam logic [15:0] CTRL_IMPL_MASK = 16'hC1FF;
  // Value after power-on: only the power-on and brown-out flags set.
  localparam logic [15:0] CTRL_POR_VALUE = 16'h0003;
  // Flags cleared by a brown-out: all but the power-on, brown-out and pin flags and control bits.
  localparam logic [15:0] CTRL_BOR_CLEAR = 16'hC05C;

  // Byte addresses on the APB.
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_ISTAT  = 12'h004;
  localparam logic [11:0] ADDR_IMASK  = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;

  // Interrupt event bits.
  localparam int EV_NUM      = 3;
  localparam int EV_RST_DONE = 0;
  localparam int EV_RST_SEEN = 1;
  localparam int EV_TRAP     = 2;

  // Internal state reset hold time.
  localparam int  CLK_HZ       = 40_000_000;
  localparam int  TRST_US      = 20;
  localparam int  TRST_CYCLES  = (TRST_US * (CLK_HZ / 1_000_000));

  typedef enum logic [1:0] {
    RSCC_IDLE,
    RSCC_HOLD
  } rscc_state_e;

endpackage

//--- design/rscc_src_if.sv
`timescale 1ns/10ps
interface rscc_src_if;
  logic hw_por;
  logic hw_bor;
  logic hw_master_clear_pin;
  logic hw_swr;
  logic hw_wdt;
  logic hw_trap;
  logic hw_iop;
  logic any_src;
  logic warm_src;

  modport combiner (
    input  hw_por, hw_bor, hw_master_clear_pin, hw_swr, hw_wdt, hw_trap, hw_iop,
    output any_src, warm_src
  );
  modport user (
    output hw_por, hw_bor, hw_master_clear_pin, hw_swr, hw_wdt, hw_trap, hw_iop,
    input  any_src, warm_src
  );
endinterface

//--- design/rscc_combiner.sv
`timescale 1ns/10ps
module rscc_combiner (
  rscc_src_if.combiner src
);
  assign src.warm_src = src.hw_master_clear_pin | src.hw_swr | src.hw_wdt
                      | src.hw_trap | src.hw_iop;  // R2
  assign src.any_src  = src.warm_src | src.hw_por | src.hw_bor;  // R1
endmodule

//--- design/rscc_hold_timer.sv
`timescale 1ns/10ps
module rscc_hold_timer #(
  parameter int HOLD_CYCLES = rscc_pkg::TRST_CYCLES
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  localparam int CW = $clog2(HOLD_CYCLES + 1);

  rscc_pkg::rscc_state_e state;
  logic [CW-1:0]         count;
  wire                   last = (count == CW'(1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= rscc_pkg::RSCC_IDLE;
      count <= '0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        rscc_pkg::RSCC_IDLE: begin
          if (start) begin
            state <= rscc_pkg::RSCC_HOLD;
            count <= CW'(HOLD_CYCLES);
          end
        end
        rscc_pkg::RSCC_HOLD: begin
          // A new source restarts the full hold.
          if (start) begin
            count <= CW'(HOLD_CYCLES);
          end else if (last) begin
            state <= rscc_pkg::RSCC_IDLE;
            done  <= 1'b1;
          end else begin
            count <= count - CW'(1);
          end
        end
        default: state <= rscc_pkg::RSCC_IDLE;
      endcase
    end
  end

  assign busy = (state == rscc_pkg::RSCC_HOLD);
endmodule

//--- design/rscc_top.sv
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/10ps
// How it works
// R1: Any active reset source drives the single master system reset.
// R2: Seven sources: power-on, brown-out, pin, instruction, watchdog, trap, illegal.
// R3: Every reset event sets its own cause flag in the control register.
// R4: Power-on clears all flags except the power-on and brown-out flags, which it sets.
// R5: Software may set or clear flags; that never causes a reset.
// R6: Trap flag bit 15 set by trap conflict, cleared by power-on or brown-out.
// R7: Illegal-operation flag bit 14, cleared by power-on or brown-out.
// R8: Pin flag bit 7 set by pin reset, cleared only by power-on.
// R9: Software-reset flag bit 6, cleared by power-on or brown-out.
// R10: Watchdog flag bit 4; power-save instruction, power-on or brown-out clear it.
// R11: Sleep bit 3 and idle bit 2 set by power-save instructions.
// R12: Power-on flag bit 0 stays set until software clears it.
// R13: Bit 5 enables the watchdog; the fuse forces it on regardless.
// R14: Bit 8 keeps the regulator active in sleep when set.
// R15: Bits 13 to 9 read as zero.
// R16: Defined registers reset; others keep contents across warm resets.
// R17: Software should clear the cause flags after reading them.
// R18: Warm resets hold the master reset for 20 us before release.
// R19: A hardware set wins over a software write in the same cycle.
module rscc_top #(
  parameter int HOLD_CYCLES = rscc_pkg::TRST_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        por_event,
  input  wire logic        bor_event,
  input  wire logic        master_clear_pin_event,
  input  wire logic        swr_event,
  input  wire logic        wdt_event,
  input  wire logic        trap_event,
  input  wire logic        iop_event,
  input  wire logic        power_save_instruction_sleep,
  input  wire logic        power_save_instruction_idle,
  input  wire logic        watchdog_config_fuse,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             master_system_reset,
  output logic             watchdog_enable,
  output logic             regulator_active_in_sleep,
  output logic             irq
);
  // The block itself is not reset by warm sources; only arst_n (power
  // supply) clears it, so the cause flags survive the reset they record.

  rscc_src_if src ();
  assign src.hw_por  = por_event;
  assign src.hw_bor  = bor_event;
  assign src.hw_master_clear_pin = master_clear_pin_event;
  assign src.hw_swr  = swr_event;
  assign src.hw_wdt  = wdt_event;
  assign src.hw_trap = trap_event;
  assign src.hw_iop  = iop_event;

  rscc_combiner u_comb (
    .src (src)
  );

  logic hold_busy;
  logic hold_done;

  rscc_hold_timer #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_hold (
    .clk    (clk),
    .arst_n (arst_n),
    .start  (src.warm_src),
    .busy   (hold_busy),
    .done   (hold_done)
  );

  // Power-on and brown-out act for as long as they are present; warm
  // sources are stretched by the hold timer.
  assign master_system_reset = src.any_src | hold_busy;  // R1 R18

  // APB decode. The slave always answers in the access cycle.
  wire        access   = psel & penable;
  wire        wr_en    = access & pwrite;
  wire        sel_ctrl = (paddr == rscc_pkg::ADDR_CTRL);
  wire        sel_ist  = (paddr == rscc_pkg::ADDR_ISTAT);
  wire        sel_imk  = (paddr == rscc_pkg::ADDR_IMASK);
  wire        sel_sts  = (paddr == rscc_pkg::ADDR_STATUS);
  wire        mapped   = sel_ctrl | sel_ist | sel_imk | sel_sts;
  wire [15:0] lane_msk = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // Cause and control register.
  logic [15:0] ctrl;
  logic [15:0] hw_set;
  logic [15:0] hw_clr;
  logic [15:0] sw_val;
  logic [15:0] next_ctrl;

  always_comb begin
    hw_set = 16'h0000;
    hw_set[rscc_pkg::BIT_POR]   = por_event;  // R3 R12
    hw_set[rscc_pkg::BIT_BOR]   = bor_event | por_event;  // R3
    hw_set[rscc_pkg::BIT_EXTERNAL_PIN_RESET_FLAG]  = master_clear_pin_event;  // R8
    hw_set[rscc_pkg::BIT_SWR]   = swr_event;  // R9
    hw_set[rscc_pkg::BIT_WATCHDOG_TIMEOUT_FLAG]  = wdt_event;  // R10
    hw_set[rscc_pkg::BIT_TRAP]  = trap_event;  // R6
    hw_set[rscc_pkg::BIT_IOP]   = iop_event;  // R7
    hw_set[rscc_pkg::BIT_SLEEP] = power_save_instruction_sleep;  // R11
    hw_set[rscc_pkg::BIT_IDLE]  = power_save_instruction_idle;  // R11
  end

  always_comb begin
    hw_clr = 16'h0000;
    if (bor_event) begin
      hw_clr = rscc_pkg::CTRL_BOR_CLEAR;  // R6 R7 R9 R10 R11
    end
    if (power_save_instruction_sleep | power_save_instruction_idle) begin
      hw_clr[rscc_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1;  // R10
    end
  end

  assign sw_val = (wr_en & sel_ctrl)
                ? ((ctrl & ~lane_msk) | (pwdata[15:0] & lane_msk))
                : ctrl;  // R5

  always_comb begin
    if (por_event) begin
      next_ctrl = rscc_pkg::CTRL_POR_VALUE;  // R4
    end else begin
      // Set is applied last so it wins over a clear or a write.
      next_ctrl = ((sw_val & ~hw_clr) | hw_set)
                & rscc_pkg::CTRL_IMPL_MASK;  // R19 R15
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= rscc_pkg::CTRL_POR_VALUE;  // R16
    end else begin
      ctrl <= next_ctrl;
    end
  end

  assign watchdog_enable = watchdog_config_fuse
                         | ctrl[rscc_pkg::BIT_WDTEN];  // R13
  assign regulator_active_in_sleep = ctrl[rscc_pkg::BIT_VREG];  // R14

  // Interrupt status, mask and line.
  localparam int N = rscc_pkg::EV_NUM;
  logic [N-1:0] istat;
  logic [N-1:0] imask;
  logic [N-1:0] ev;
  logic         rst_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 1'b0;
    end else begin
      rst_q <= src.any_src;
    end
  end

  always_comb begin
    ev = '0;
    ev[rscc_pkg::EV_RST_DONE] = hold_done;
    ev[rscc_pkg::EV_RST_SEEN] = src.any_src & ~rst_q;
    ev[rscc_pkg::EV_TRAP]     = trap_event;
  end

  wire [N-1:0] w1c = (wr_en & sel_ist & pstrb[0]) ? pwdata[N-1:0] : '0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      istat <= '0;
      imask <= '0;
    end else begin
      istat <= (istat & ~w1c) | ev;
      if (wr_en & sel_imk & pstrb[0]) begin
        imask <= pwdata[N-1:0];
      end
    end
  end

  assign irq = |(istat & imask);

  // Read mux registered on the setup cycle so prdata comes from flops.
  logic [31:0] rd_sel;

  always_comb begin
    rd_sel = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_sel = {16'h0000, ctrl};
    end else if (sel_ist) begin
      rd_sel = {{(32-N){1'b0}}, istat};
    end else if (sel_imk) begin
      rd_sel = {{(32-N){1'b0}}, imask};
    end else if (sel_sts) begin
      rd_sel = {29'h0, watchdog_enable, hold_busy, master_system_reset};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_sel;
    end
  end
endmodule

//--- test/rscc_top_asserts.sv
`timescale 1ns/10ps
module rscc_top_asserts (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        por_event,
  input wire logic        bor_event,
  input wire logic        master_clear_pin_event,
  input wire logic        swr_event,
  input wire logic        wdt_event,
  input wire logic        trap_event,
  input wire logic        iop_event,
  input wire logic        watchdog_config_fuse,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        master_system_reset,
  input wire logic        watchdog_enable,
  input wire logic        regulator_active_in_sleep
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic warm = master_clear_pin_event | swr_event | wdt_event | trap_event
                  | iop_event;
  wire logic src = warm | por_event | bor_event;
  wire logic wr = psel & penable & pwrite;
  wire logic wr0 = wr & (paddr == 12'h000) & ~por_event;
  chk_src_reset: assert property (src |-> master_system_reset)
    else $error("source without system reset");
  chk_warm_hold: assert property (
    $fell(warm) |-> master_system_reset[*3])
    else $error("warm reset not stretched");
  chk_sw_no_reset: assert property (
    wr && !src && !master_system_reset |=> !master_system_reset || src)
    else $error("register write caused a reset");
  chk_wdt_write: assert property (
    wr0 && pstrb[0] |=>
      watchdog_enable == ($past(pwdata[5]) | watchdog_config_fuse))
    else $error("watchdog enable wrong after write");
  chk_fuse_force: assert property (
    watchdog_config_fuse |-> watchdog_enable)
    else $error("fuse did not force watchdog on");
  chk_vreg_write: assert property (
    wr0 && pstrb[1] |=> regulator_active_in_sleep == $past(pwdata[8]))
    else $error("regulator control wrong after write");
  chk_por_clear: assert property (
    por_event |=> !regulator_active_in_sleep
      && (!watchdog_enable || watchdog_config_fuse))
    else $error("power-on left a control bit set");
  chk_bor_keep: assert property (
    bor_event && !por_event && !wr |=> $stable(regulator_active_in_sleep))
    else $error("brown-out changed regulator control");
endmodule
bind rscc_top rscc_top_asserts u_chk (.*);

//--- test/tb_rscc_top.sv
`timescale 1ns/10ps
module tb_rscc_top;
  localparam int HOLD = 8;
  localparam logic [15:0] FLAG [7] = '{16'h0003, 16'h0002, 16'h0080,
    16'h0040, 16'h0010, 16'h8000, 16'h4000};
  logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, watchdog_config_fuse = 1'b0;
  logic [8:0]  ev = 9'h000;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, master_system_reset, watchdog_enable;
  logic        regulator_active_in_sleep, irq, err;
  int          error_cnt = 0;
  int          check_count = 0;
  // Events 0 to 6 are the reset sources, 7 and 8 the power-save pulses.
  rscc_top #(.HOLD_CYCLES(HOLD)) u_dut (
    .clk, .arst_n, .por_event(ev[0]), .bor_event(ev[1]), .master_clear_pin_event(ev[2]),
    .swr_event(ev[3]), .wdt_event(ev[4]), .trap_event(ev[5]),
    .iop_event(ev[6]), .power_save_instruction_sleep(ev[7]), .power_save_instruction_idle(ev[8]),
    .watchdog_config_fuse, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .master_system_reset,
    .watchdog_enable, .regulator_active_in_sleep, .irq);
  initial forever #12.5 clk = ~clk;
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("%0d checks, %0d mismatches", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    if (n == 50) begin
      error_cnt++;
      report_and_stop();
    end
  endtask
  task automatic rdchk(logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Warm sources are followed until the stretched reset lets go, so no
  // register access lands while the device is still held.
  task automatic pulse(int i);
    int n;
    n = 0;
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
    if (i < 2 || i > 6) return;
    while (master_system_reset !== 1'b0 && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'(n >= HOLD && n <= HOLD + 3), 32'h1);
    if (n == 1000) report_and_stop();
  endtask
  task automatic t_reset();
    rdchk(12'h000, 32'h3);
    pstrb <= 4'h1;
    apb(1'b1, 12'h000, 32'hFFFF);
    pstrb <= 4'hF;
    rdchk(12'h000, 32'hFF);
    apb(1'b1, 12'h000, 32'hFFFF);
    rdchk(12'h000, 32'hC1FF);
    $display("reset and access test done");
  endtask
  task automatic t_causes();
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, 12'h000, 32'h0);
      pulse(i);
      rdchk(12'h000, {16'h0, FLAG[i]});
    end
    $display("cause flag test done");
  endtask
  task automatic t_clear();
    apb(1'b1, 12'h000, 32'hC1FD);
    pulse(1);
    rdchk(12'h000, 32'h1A3);
    apb(1'b1, 12'h000, 32'h10);
    pulse(7);
    rdchk(12'h000, 32'h8);
    pulse(8);
    rdchk(12'h000, 32'hC);
    $display("flag clear test done");
  endtask
  task automatic t_outs();
    apb(1'b1, 12'h000, 32'h120);
    #1;
    chk(watchdog_enable, 32'h1);
    chk(regulator_active_in_sleep, 32'h1);
    apb(1'b1, 12'h000, 32'h0);
    #1;
    chk({watchdog_enable, regulator_active_in_sleep}, 32'h0);
    @(posedge clk) watchdog_config_fuse <= 1'b1;
    #1;
    chk(watchdog_enable, 32'h1);
    rdchk(12'h00C, 32'h4);
    @(posedge clk) watchdog_config_fuse <= 1'b0;
    $display("control output test done");
  endtask
  task automatic t_irq();
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h004, 32'h7);
    pulse(2);
    rdchk(12'h004, 32'h3);
    chk(irq, 32'h0);
    apb(1'b1, 12'h008, 32'h1);
    #1;
    chk(irq, 32'h1);
    apb(1'b1, 12'h004, 32'h1);
    rdchk(12'h004, 32'h2);
    chk(irq, 32'h0);
    rdchk(12'h010, 32'h0);
    chk(err, 32'h1);
    $display("interrupt and decode test done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_causes();
    t_clear();
    t_outs();
    t_irq();
    report_and_stop();
  end
endmodule
